// >>> rtl/ppsc_pkg.sv
/*
 * Constants and types for the power state control register block.
 * Assumes a single 20 MHz clock domain and a configuration-space access port.
 */
package ppsc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0]  PPSC_PWR_CTRL_STATUS_OFS = 8'h7C;

    // ==========================================================
    // Field positions
    localparam int          PPSC_WAKE_FLAG_BIT       = 15;
    localparam int          PPSC_WAKE_EN_BIT         = 8;
    localparam int          PPSC_STATE_LSB           = 0;

    // ==========================================================
    // Reset values and encodings
    localparam logic [1:0]  PPSC_STATE_D0            = 2'h0;
    localparam logic [1:0]  PPSC_STATE_D3            = 2'h3;
    localparam logic [1:0]  PPSC_STATE_RST           = 2'h0;
    localparam logic        PPSC_FLAG_RST            = 1'h0;
    localparam logic        PPSC_EN_RST              = 1'h0;

    // ==========================================================
    // Types
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } ppsc_cfg_req_type;

    typedef enum logic {
        PPSC_PWR_D0,
        PPSC_PWR_D3
    } ppsc_pwr_type;

endpackage : ppsc_pkg

// >>> rtl/ppsc_power_ctrl.sv
/*
 * Power management control and status register with wake request pin
 * and PHY power-down request.
 * Assumes configuration accesses are single-cycle strobes on clk, and that
 * the wake source and aux detect come from outside the clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module ppsc_power_ctrl
    import ppsc_pkg::*;
(
    // Clock and power-on reset
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // Host bus reset, synchronous to clk
    input  wire logic                       host_bus_reset_n,
    // Configuration access
    input  wire ppsc_pkg::ppsc_cfg_req_type cfg_req,
    output var  logic [31:0]                cfg_rdata,
    output var  logic                       cfg_ack,
    // Wake event source and aux supply detect, asynchronous
    input  wire logic                       wake_source,
    input  wire logic                       aux_supply_detect,
    // Outputs
    output var  logic                       wake_request_n,
    output var  logic                       phy_power_down,
    output var  logic                       in_d3
);
    import ppsc_pkg::*;

    // ==========================================================
    // Helpers

    // True for the state code of the low-power state.
    function automatic logic is_d3(input logic [1:0] code);
        return (code == PPSC_STATE_D3);
    endfunction : is_d3

    // Only D0 and D3 may be written; the two other codes are reserved.
    function automatic logic state_legal(input logic [1:0] code);
        return (code == PPSC_STATE_D0) || is_d3(code);
    endfunction : state_legal

    // ==========================================================
    // Input synchronisation
    logic src_s;
    logic aux_s;

    // Both inputs are slow levels from outside this clock domain; the
    // agreement filter keeps a one-cycle glitch from reaching the flag.
    ppsc_sync u_src_sync
    (
        .clk    (clk),
        .resetn (resetn),
        .din    (wake_source),
        .dout   (src_s)
    );

    ppsc_sync u_aux_sync
    (
        .clk    (clk),
        .resetn (resetn),
        .din    (aux_supply_detect),
        .dout   (aux_s)
    );

    // ==========================================================
    // Registers
    logic [1:0]  power_state_field_r;
    logic [1:0]  power_state_field_nxt;
    logic        wake_event_flag_r;
    logic        wake_event_flag_nxt;
    logic        wake_request_enable_r;
    logic        wake_request_enable_nxt;
    logic        wake_request_n_r;
    logic        phy_power_down_r;
    logic        in_d3_r;
    logic [31:0] cfg_rdata_r;
    logic        cfg_ack_r;

    // ==========================================================
    // Decode

    // Byte lanes 0 and 1 carry the writable fields; lanes 2 and 3 hold
    // read-only zeros, so their enables are not looked at.
    wire logic hit    = (cfg_req.addr == PPSC_PWR_CTRL_STATUS_OFS);
    wire logic wr_hit = cfg_req.wr && hit;
    wire logic rd_hit = cfg_req.rd && hit;
    wire logic wr_lo  = wr_hit && cfg_req.be[0];
    wire logic wr_hi  = wr_hit && cfg_req.be[1];
    wire logic [1:0] wr_state = cfg_req.wdata[PPSC_STATE_LSB +: 2];

    wire logic state_ok = state_legal(wr_state);

    wire logic flag_clr = wr_hi && cfg_req.wdata[PPSC_WAKE_FLAG_BIT]
                       && !src_s;

    wire logic flag_set = src_s && wake_request_enable_r;

    // A host bus reset always returns the state to D0, but the wake bits
    // outlive it while aux power is present so that a wake can follow.
    // bus reset retention
    wire logic bus_rst  = !host_bus_reset_n && !aux_s;
    wire logic pci_rst  = !host_bus_reset_n;

    assign power_state_field_nxt = pci_rst ? PPSC_STATE_RST
        : ((wr_lo && state_ok) ? wr_state : power_state_field_r);

    // Set wins over clear, so an event that arrives together with a
    // clearing write is not lost.
    assign wake_event_flag_nxt = bus_rst ? PPSC_FLAG_RST
        : (flag_set || (wake_event_flag_r && !flag_clr));

    assign wake_request_enable_nxt = bus_rst ? PPSC_EN_RST
        : (wr_hi ? cfg_req.wdata[PPSC_WAKE_EN_BIT]
                 : wake_request_enable_r);

    wire logic entering_d3 = is_d3(power_state_field_nxt);

    wire logic [31:0] rd_word = {16'h0000, wake_event_flag_r, 6'h00,
                                 wake_request_enable_r, 6'h00,
                                 power_state_field_r};

    // ==========================================================
    // Power state register
    always_ff @(posedge clk)
    begin
        if (!resetn)
            power_state_field_r <= PPSC_STATE_RST;
        else
            power_state_field_r <= power_state_field_nxt;
    end

    // ==========================================================
    // Wake event flag and wake enable

    // Power-on reset clears both bits whatever the aux detect level.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            wake_event_flag_r <= PPSC_FLAG_RST;
        else
            wake_event_flag_r <= wake_event_flag_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            wake_request_enable_r <= PPSC_EN_RST;
        else
            wake_request_enable_r <= wake_request_enable_nxt;
    end

    // ==========================================================
    // Pins

    // The pins follow the next register values so that they change on
    // the same edge as the fields that the host reads back.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wake_request_n_r <= 1'h1;
            phy_power_down_r <= 1'h0;
            in_d3_r          <= 1'h0;
        end
        else
        begin
            wake_request_n_r <= !(wake_event_flag_nxt
                                  && wake_request_enable_nxt);
            phy_power_down_r <= entering_d3 && !wake_request_enable_nxt;
            in_d3_r          <= entering_d3;
        end
    end

    // ==========================================================
    // Configuration answer

    // Every strobe is answered, also at other offsets, so that the
    // host never waits on this block; reads elsewhere return zero.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cfg_rdata_r <= 32'h0000_0000;
            cfg_ack_r   <= 1'h0;
        end
        else
        begin
            cfg_rdata_r <= rd_hit ? rd_word : 32'h0000_0000;
            cfg_ack_r   <= cfg_req.wr || cfg_req.rd;
        end
    end

    // ==========================================================
    // Outputs
    assign wake_request_n = wake_request_n_r;
    assign phy_power_down = phy_power_down_r;
    assign in_d3          = in_d3_r;
    assign cfg_rdata      = cfg_rdata_r;
    assign cfg_ack        = cfg_ack_r;
endmodule : ppsc_power_ctrl
`default_nettype wire

// >>> rtl/ppsc_sync.sv
/*
 * Three-flop input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module ppsc_sync
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Asynchronous input and filtered level
    input  wire logic din,
    output var  logic dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic dout_r;
    wire  logic agree = (s2_r == s3_r);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s1_r   <= 1'h0;
            s2_r   <= 1'h0;
            s3_r   <= 1'h0;
            dout_r <= 1'h0;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (agree)
                dout_r <= s3_r;
        end
    end

    assign dout = dout_r;
endmodule : ppsc_sync
`default_nettype wire

// >>> tb/ppsc_host_model.sv
/* Host model issuing single-cycle configuration strobes.
   Assumes cfg_ack answers a strobe within a few clocks. */
`timescale 1ns/100ps
`default_nettype none
module ppsc_host_model
    import ppsc_pkg::*;
(
    // Clock
    input  wire logic                       clk,
    // Configuration access
    output var  ppsc_pkg::ppsc_cfg_req_type cfg_req,
    input  wire logic                       cfg_ack,
    input  wire logic [31:0]                cfg_rdata
);
    initial cfg_req = '0;
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cfg_req <= '{w, !w, a, 4'hF, d};
        @(posedge clk);
        // Released lines show the inverse so stale values cannot pass.
        cfg_req <= '{1'b0, 1'b0, ~a, 4'h0, ~d};
        // The answer stands in the cycle after the strobe; take it at
        // the edge that closes that cycle.
        @(posedge clk);
        for (int i = 0; i < 4 && cfg_ack !== 1'b1; i++)
            @(posedge clk);
        q = (cfg_ack === 1'b1) ? cfg_rdata : 32'hBAD0BAD0;
    endtask : access
endmodule : ppsc_host_model
`default_nettype wire

// >>> tb/ppsc_power_ctrl_assertions.sv
/* Port checks for the power state control block.
   Assumes one clock domain; bound at the foot of this file. */
`timescale 1ns/100ps
`default_nettype none
module ppsc_power_ctrl_assertions
    import ppsc_pkg::*;
(
    // Clock and resets
    input wire logic                       clk,
    input wire logic                       resetn,
    input wire logic                       host_bus_reset_n,
    // Configuration access
    input wire ppsc_pkg::ppsc_cfg_req_type cfg_req,
    input wire logic [31:0]                cfg_rdata,
    input wire logic                       cfg_ack,
    // Pins
    input wire logic                       wake_source,
    input wire logic                       aux_supply_detect,
    input wire logic                       wake_request_n,
    input wire logic                       phy_power_down,
    input wire logic                       in_d3
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_wr;
        cfg_req.wr && cfg_req.addr == PPSC_PWR_CTRL_STATUS_OFS
            && cfg_req.be[0] && cfg_req.be[1] && host_bus_reset_n;
    endsequence
    ack_follow_a: assert property (
        (cfg_req.wr || cfg_req.rd) |=> cfg_ack)
        else $error("no ack after request");
    ack_cause_a: assert property (
        cfg_ack |-> $past(cfg_req.wr || cfg_req.rd))
        else $error("ack without request");
    wake_pd_a: assert property (
        !wake_request_n |-> !phy_power_down)
        else $error("power down while wake requested");
    zero_fields_a: assert property (cfg_ack |-> cfg_rdata[31:16] == 16'h0000
        && cfg_rdata[14:9] == 6'h00 && cfg_rdata[7:2] == 6'h00)
        else $error("unimplemented bits not zero");
    state_d3_a: assert property (s_wr ##0 cfg_req.wdata[1:0] == 2'h3 |=> in_d3)
        else $error("state write ignored");
    state_keep_a: assert property (s_wr ##0 cfg_req.wdata[1:0] inside
        {2'h1, 2'h2} |=> $stable(in_d3)) else $error("reserved state taken");
    bus_rst_d0_a: assert property (!host_bus_reset_n |=> !in_d3)
        else $error("bus reset left state");
    en_off_a: assert property (s_wr ##0 !cfg_req.wdata[8] |=> wake_request_n)
        else $error("wake request while disabled");
    pd_enter_a: assert property (s_wr ##0 cfg_req.wdata[1:0] == 2'h3
        && !cfg_req.wdata[8] |=> phy_power_down) else $error("no power down");
    pd_d3_a: assert property (phy_power_down |-> in_d3)
        else $error("power down outside D3");
endmodule : ppsc_power_ctrl_assertions
bind ppsc_power_ctrl ppsc_power_ctrl_assertions ppsc_power_ctrl_assertions_i (
    .clk(clk), .resetn(resetn), .host_bus_reset_n(host_bus_reset_n),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .wake_source(wake_source), .aux_supply_detect(aux_supply_detect),
    .wake_request_n(wake_request_n), .phy_power_down(phy_power_down),
    .in_d3(in_d3));
`default_nettype wire

// >>> tb/tb.sv
/* Self-checking bench with a reference model of the register.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ppsc_pkg::*;
    logic             clk = 0, resetn = 0, host_bus_reset_n = 1;
    logic             wake_source = 0, aux_supply_detect = 0;
    logic             cfg_ack, wake_request_n, phy_power_down, in_d3;
    logic [31:0]      cfg_rdata, q;
    logic [15:0]      rnd = 16'h0037;
    ppsc_cfg_req_type cfg_req;
    int               num_errors = 0, comparisons = 0, cycles = 0;
    int               m_state = 0, m_flag = 0, m_en = 0;
    always #25 clk = ~clk;
    ppsc_power_ctrl ppsc_power_ctrl_i (.clk(clk), .resetn(resetn),
        .host_bus_reset_n(host_bus_reset_n), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .wake_source(wake_source),
        .aux_supply_detect(aux_supply_detect), .in_d3(in_d3),
        .wake_request_n(wake_request_n), .phy_power_down(phy_power_down));
    ppsc_host_model ppsc_host_model_i (.clk(clk), .cfg_req(cfg_req),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic check_all;
        ppsc_host_model_i.access(1'b0, 8'h7C, 32'h0, q);
        chk(q, {m_flag[0], 6'h00, m_en[0], 6'h00, m_state[1:0]});
        chk(wake_request_n, !(m_flag && m_en));
        chk(phy_power_down, m_state == 3 && !m_en);
        chk(in_d3, m_state == 3);
    endtask : check_all
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        if (wake_source && m_en)
            m_flag = 1;
    endtask : idle
    task automatic wr(input logic [31:0] d);
        ppsc_host_model_i.access(1'b1, 8'h7C, d, q);
        chk(q, 32'h0);
        if (d[1:0] == 2'h0 || d[1:0] == 2'h3)
            m_state = d[1:0];
        m_en = d[8];
        if (d[15] && !wake_source)
            m_flag = 0;
        check_all;
    endtask : wr
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1;
        check_all;
        for (int i = 0; i < 16; i++)
        begin
            rnd = lfsr(rnd);
            wr({~rnd, rnd});
        end
        ppsc_host_model_i.access(1'b1, 8'h40, 32'hFFFFFFFF, q);
        chk(q, 32'h0);
        check_all;
        ppsc_host_model_i.access(1'b0, 8'h78, 32'h0, q);
        chk(q, 32'h0);
        wr(32'h00000100);
        wake_source <= 1;
        idle(8);
        check_all;
        wr(32'h00008100);
        wr(32'h00000003);
        wake_source <= 0;
        idle(8);
        wr(32'h00008100);
        for (int a = 2; a >= 0; a--)
        begin
            aux_supply_detect <= (a != 0);
            wr(32'h00000103);
            wake_source <= 1;
            idle(8);
            wake_source <= 0;
            if (a == 2)
                resetn <= 0;
            else
                host_bus_reset_n <= 0;
            idle(4);
            resetn <= 1;
            host_bus_reset_n <= 1;
            m_state = 0;
            m_flag = (a == 1) ? m_flag : 0;
            m_en = (a == 1) ? m_en : 0;
            check_all;
        end
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
